// >>> bench/ptc_pin_src.sv
// far-side pulse source driving the timer i/o pin and the timer clock pin
`timescale 1ns/1ps
module ptc_pin_src (
    input  wire logic i_clk,    // system clock
    input  wire logic i_slow,   // long hold between edges when high
    output logic      o_io,     // timer i/o pin level
    output logic      o_ck      // timer clock pin level
);
    initial o_io = 1'b0;
    initial o_ck = 1'b0;

    // move the i/o pin, then hold it well past the two-stage synchroniser
    task automatic set_io(input logic v);
        @(posedge i_clk);
        o_io <= v;
        repeat (i_slow ? 20 : 6) @(posedge i_clk);
    endtask

    // whole clock pin pulses, each phase held past the synchroniser
    task automatic pulse_ck(input int n);
        repeat (n) begin
            @(posedge i_clk);
            o_ck <= 1'b1;
            repeat (i_slow ? 20 : 6) @(posedge i_clk);
            o_ck <= 1'b0;
            repeat (i_slow ? 20 : 6) @(posedge i_clk);
        end
    endtask
endmodule

// >>> bench/ptc_timer_tb.sv
// self-checking bench for the periodic timer in capture mode
`timescale 1ns/1ps
`include "ptc_params.svh"
module ptc_timer_tb;
    logic        i_clk, i_rst, i_hs_clk_en, i_tbc_clk_en;
    logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [11:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, seed;
    logic [3:0]  i_wstrb;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_capture_irq, o_period_irq;
    logic        o_timer_io_out, o_timer_io_oe_n, io_pin, ck_pin, cap_q = 1'b0, per_q = 1'b0;
    logic [1:0]  o_bresp, o_rresp, e2;
    logic [31:0] o_rdata;
    logic [33:0] e34;
    logic [7:0]  cnt, cap_v;
    logic [1:0]  wq[$];
    logic [33:0] rq[$];
    int          fails = 0, check_count = 0, caps = 0, pers = 0, exp_caps = 0, cyc = 0;

    ptc_timer u_ptc_timer (.i_clk(i_clk), .i_rst(i_rst), .i_hs_clk_en(i_hs_clk_en), .i_tbc_clk_en(i_tbc_clk_en),
        .i_timer_io_pin(io_pin), .i_timer_clock_pin(ck_pin), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
        .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
        .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
        .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
        .o_capture_irq(o_capture_irq), .o_period_irq(o_period_irq), .o_timer_io_out(o_timer_io_out),
        .o_timer_io_oe_n(o_timer_io_oe_n));
    ptc_pin_src u_ptc_pin_src (.i_clk(i_clk), .i_slow(seed[0]), .o_io(io_pin), .o_ck(ck_pin));

    always #2 i_clk = ~i_clk;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // ----------------------------------------
    // free-running stimulus, event counters, hang guard
    // ----------------------------------------
    always @(posedge i_clk) begin
        seed <= lfsr_next(seed);
        i_hs_clk_en <= ~i_hs_clk_en;
        i_tbc_clk_en <= seed[5];
        cap_q <= o_capture_irq;
        per_q <= o_period_irq;
        if (o_capture_irq === 1'b1 && !cap_q) caps <= caps + 1;
        if (o_period_irq === 1'b1 && !per_q) pers <= pers + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            test_done();
        end
    end

    // ----------------------------------------
    // response watcher: oldest note against each answer
    // ----------------------------------------
    always @(negedge i_clk) begin
        if (o_bvalid === 1'b1 && i_bready) begin
            e2 = wq.pop_front();
            check_count++;
            if (o_bresp !== e2) begin
                fails++;
                $display("CHECK FAILED %0t bresp %h exp %h", $time, o_bresp, e2);
            end
        end
        if (o_rvalid === 1'b1 && i_rready) begin
            e34 = rq.pop_front();
            check_count++;
            if ({o_rresp, o_rdata} !== e34) begin
                fails++;
                $display("CHECK FAILED %0t read %h_%h exp %h", $time, o_rresp, o_rdata, e34);
            end
        end
    end

    // axi write; each channel released at the edge where it is taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ah, wh, ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        wq.push_back(er);
        @(posedge i_clk);
        i_awaddr <= a;
        i_wdata <= {24'h00_0000, d};
        i_wstrb <= {seed[3:1], 1'b1};
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do begin
            @(negedge i_clk);
            ah = i_awvalid & o_awready;
            wh = i_wvalid & o_wready;
            @(posedge i_clk);
            if (ah) i_awvalid <= 1'b0;
            if (wh) i_wvalid <= 1'b0;
            ad |= ah;
            wd |= wh;
        end while (!(ad && wd));
        do @(negedge i_clk); while (o_bvalid !== 1'b1);
        @(posedge i_clk);
        i_bready <= 1'b0;
    endtask

    // axi read; the watcher compares the answer with the note
    task automatic rd(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
        logic ah;
        rq.push_back({er, 24'h00_0000, ed});
        @(posedge i_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do begin
            @(negedge i_clk);
            ah = o_arready;
            @(posedge i_clk);
        end while (!ah);
        i_arvalid <= 1'b0;
        do @(negedge i_clk); while (o_rvalid !== 1'b1);
        @(posedge i_clk);
        i_rready <= 1'b0;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t value %h exp %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        i_clk = 1'b0;
        i_rst = 1'b1;
        seed = 32'h5e7d_7f4a;
        {i_hs_clk_en, i_tbc_clk_en, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 7'h00;
        {i_awaddr, i_araddr, i_wdata, i_wstrb} = 60'h000_0000_0000_0000;
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(`PTC_OFF_CTRL0, 8'h00, 2'b00);
        rd(`PTC_OFF_CTRL1, 8'h00, 2'b00);
        rd(12'h030, 8'h00, 2'b10);
        wr(12'h030, 8'hff, 2'b10);
        cap_v = seed[7:0];
        wr(`PTC_OFF_CMPA_LO, cap_v, 2'b00);
        wr(`PTC_OFF_CMPA_HI, 8'h00, 2'b00);
        rd(`PTC_OFF_CMPA_LO, cap_v, 2'b00);
        wr(`PTC_OFF_CTRL1, 8'h4d, 2'b00);
        cmp({30'h0000_0000, o_timer_io_out, o_timer_io_oe_n}, 32'h0000_0001);
        // pin clock on rising edges, run bit raised
        wr(`PTC_OFF_CTRL0, 8'h68, 2'b00);
        u_ptc_pin_src.pulse_ck(5);
        cnt = 8'h05;
        rd(`PTC_OFF_CNT_LO, cnt, 2'b00);
        rd(`PTC_OFF_CNT_HI, 8'h00, 2'b00);
        // every edge selection: rising edge, then falling edge
        for (int fn = 0; fn < 4; fn++) begin
            wr(`PTC_OFF_CTRL1, 8'h4d | (8'(fn) << 4), 2'b00);
            u_ptc_pin_src.pulse_ck(1);
            cnt++;
            u_ptc_pin_src.set_io(1'b1);
            if (fn == 0 || fn == 2) begin
                cap_v = cnt;
                exp_caps++;
            end
            rd(`PTC_OFF_CMPA_LO, cap_v, 2'b00);
            u_ptc_pin_src.pulse_ck(1);
            cnt++;
            u_ptc_pin_src.set_io(1'b0);
            if (fn == 1 || fn == 2) begin
                cap_v = cnt;
                exp_caps++;
            end
            rd(`PTC_OFF_CMPA_LO, cap_v, 2'b00);
        end
        cmp(caps, exp_caps);
        rd(`PTC_OFF_CNT_LO, cnt, 2'b00);
        // pause freezes the count but capture still latches
        wr(`PTC_OFF_CTRL1, 8'h4d, 2'b00);
        wr(`PTC_OFF_CTRL0, 8'he8, 2'b00);
        u_ptc_pin_src.pulse_ck(3);
        rd(`PTC_OFF_CNT_LO, cnt, 2'b00);
        u_ptc_pin_src.set_io(1'b1);
        u_ptc_pin_src.set_io(1'b0);
        rd(`PTC_OFF_CMPA_LO, cnt, 2'b00);
        wr(`PTC_OFF_CTRL0, 8'h68, 2'b00);
        u_ptc_pin_src.pulse_ck(1);
        cnt++;
        rd(`PTC_OFF_CNT_LO, cnt, 2'b00);
        // run low keeps the value, run high clears it
        wr(`PTC_OFF_CTRL0, 8'h60, 2'b00);
        u_ptc_pin_src.pulse_ck(2);
        rd(`PTC_OFF_CNT_LO, cnt, 2'b00);
        wr(`PTC_OFF_CTRL0, 8'h68, 2'b00);
        rd(`PTC_OFF_CNT_LO, 8'h00, 2'b00);
        // short period gives repeated matches
        wr(`PTC_OFF_PER_LO, 8'h03, 2'b00);
        u_ptc_pin_src.pulse_ck(8);
        cmp(pers, 32'h0000_0002);
        rd(`PTC_OFF_CNT_LO, 8'h00, 2'b00);
        rd(`PTC_OFF_CNT_HI, 8'h00, 2'b00);
        // both event flags stand, then clear on a write of ones
        rd(`PTC_OFF_EVENTS, 8'h03, 2'b00);
        wr(`PTC_OFF_EVENTS, 8'h03, 2'b00);
        rd(`PTC_OFF_EVENTS, 8'h00, 2'b00);
        // capture source moved to the clock pin
        wr(`PTC_OFF_CTRL1, 8'h4f, 2'b00);
        u_ptc_pin_src.set_io(1'b1);
        u_ptc_pin_src.set_io(1'b0);
        cmp(caps, exp_caps + 1);
        u_ptc_pin_src.pulse_ck(1);
        cmp(caps, exp_caps + 2);
        test_done();
    end
endmodule

// >>> verilog/ptc_params.svh
// register offsets, field positions, reset values and clock divider counts for the periodic timer
`ifndef PTC_PARAMS_SVH
`define PTC_PARAMS_SVH
`define PTC_OFF_CTRL0     12'h000
`define PTC_OFF_CTRL1     12'h004
`define PTC_OFF_CNT_LO    12'h008
`define PTC_OFF_CNT_HI    12'h00C
`define PTC_OFF_CMPA_LO   12'h010
`define PTC_OFF_CMPA_HI   12'h014
`define PTC_OFF_PER_LO    12'h018
`define PTC_OFF_PER_HI    12'h01C
`define PTC_OFF_EVENTS    12'h020
`define PTC_BIT_PAUSE     7
`define PTC_BIT_RUN       3
`define PTC_CTRL0_MASK    8'hF8
`define PTC_RST_CTRL      8'h00
`define PTC_MODE_CAPTURE  2'b01
`define PTC_DIV_SYS4      4
`define PTC_DIV_HS16      16
`define PTC_DIV_HS64      64
`endif

// >>> verilog/ptc_pkg.sv
// types shared by the periodic timer with capture
package ptc_pkg;
    typedef enum logic [1:0] {
        PTC_MODE_CMP  = 2'b00,
        PTC_MODE_CAP  = 2'b01,
        PTC_MODE_PWM  = 2'b10,
        PTC_MODE_TMR  = 2'b11
    } ptc_mode_t;

    typedef enum logic [1:0] {
        PTC_EDGE_RISE = 2'b00,
        PTC_EDGE_FALL = 2'b01,
        PTC_EDGE_BOTH = 2'b10,
        PTC_EDGE_OFF  = 2'b11
    } ptc_edge_t;

    typedef struct packed {
        logic       counter_pause_bit;
        logic [2:0] count_clock_select;
        logic       counter_run_bit;
    } ptc_ctrl0_t;

    typedef struct packed {
        ptc_mode_t  mode_select;
        ptc_edge_t  pin_function;
        logic       output_level_control;
        logic       output_invert;
        logic       capture_source_select;
        logic       clear_source_select;
    } ptc_ctrl1_t;

    // write-side state of the axi slave
    typedef enum logic [1:0] {
        PTC_WR_IDLE = 2'b00,
        PTC_WR_RESP = 2'b01
    } ptc_wr_state_t;
endpackage

// >>> verilog/ptc_timer.sv
// periodic 10-bit timer with capture input mode, reached over axi4-lite
`timescale 1ns/1ps
`include "ptc_params.svh"

// Behaviour
// - Mode field value 01 selects capture input operation.
// - Capture edge selectable: rising, falling or both.
// - Counter starts when run bit goes low to high.
// - Active edge copies counter into compare-A and raises interrupt.
// - Captures never stop or clear the counter.
// - Period match clears counter and raises interrupt.
// - Pin function 11 disables capture; counter keeps running.
// - Capture watches the I/O pin even when it drives out.
// - Clear source bit ignored in capture mode.
// - Output control and invert ignored; no output driven in capture.
// - Period value zero lets counter use full range.
// - 10-bit up counter from selectable internal or external clock.
// - Two comparators track the period value and the all-ones overflow.
// - Software clears counter only by run rising; hardware on overflow/match.
// - Pause bit 7 freezes counter; clearing resumes from held value.
// - Three-bit clock select picks among eight count clock sources.
// - Counter read-only pair; compare-A and period read/write pairs.
// - Pin function 00 rise, 01 fall, 10 both, 11 off.
// - Run rising clears counter; run falling holds residual value.
// - Capture source: 0 I/O pin, 1 clock pin.
// - Mode field 00 compare, 01 capture, 10 pwm, 11 timer.
module ptc_timer #(
    parameter int CNT_W = 10                       // counter width
) (
    input  wire logic        i_clk,                // system clock, 250 mhz
    input  wire logic        i_rst,                // synchronous reset, active high
    input  wire logic        i_hs_clk_en,          // high-speed clock tick
    input  wire logic        i_tbc_clk_en,         // time-base clock tick
    input  wire logic        i_timer_io_pin,       // timer i/o pin level
    input  wire logic        i_timer_clock_pin,    // timer clock pin level
    input  wire logic [11:0] i_awaddr,             // write address
    input  wire logic        i_awvalid,            // write address valid
    output logic             o_awready,            // write address ready
    input  wire logic [31:0] i_wdata,              // write data
    input  wire logic [3:0]  i_wstrb,              // write strobes
    input  wire logic        i_wvalid,             // write data valid
    output logic             o_wready,             // write data ready
    output logic [1:0]       o_bresp,              // write response
    output logic             o_bvalid,             // write response valid
    input  wire logic        i_bready,             // write response ready
    input  wire logic [11:0] i_araddr,             // read address
    input  wire logic        i_arvalid,            // read address valid
    output logic             o_arready,            // read address ready
    output logic [31:0]      o_rdata,              // read data
    output logic [1:0]       o_rresp,              // read response
    output logic             o_rvalid,             // read data valid
    input  wire logic        i_rready,             // read data ready
    output logic             o_capture_irq,        // capture event pulse
    output logic             o_period_irq,         // period match pulse
    output logic             o_timer_io_out,       // pin drive level, unused here
    output logic             o_timer_io_oe_n       // pin drive enable, low drives
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // byte lane merge for an 8-bit register
    function automatic logic [7:0] lane_merge(input logic [7:0] old_v, input logic [31:0] wd,
                                              input logic [3:0] st);
        lane_merge = st[0] ? wd[7:0] : old_v;
    endfunction

    // edge detect per the pin function field
    function automatic logic edge_hit(input ptc_pkg::ptc_edge_t sel, input logic now_v,
                                      input logic prev_v);
        case (sel)
            ptc_pkg::PTC_EDGE_RISE: edge_hit = now_v & ~prev_v;
            ptc_pkg::PTC_EDGE_FALL: edge_hit = ~now_v & prev_v;
            ptc_pkg::PTC_EDGE_BOTH: edge_hit = now_v ^ prev_v;
            default:                edge_hit = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    ptc_pkg::ptc_ctrl0_t     ctrl0_q;
    ptc_pkg::ptc_ctrl1_t     ctrl1_q;
    logic [CNT_W-1:0]        count_q;
    logic [CNT_W-1:0]        cmpa_q;
    logic [CNT_W-1:0]        per_q;
    logic                    run_prev_q;
    logic [5:0]              div_q;
    logic                    io_s1_q, io_s2_q, io_s3_q;
    logic                    ck_s1_q, ck_s2_q, ck_s3_q;
    logic                    cap_flag_q, per_flag_q;
    logic                    cap_irq_q, per_irq_q;
    ptc_pkg::ptc_wr_state_t  wr_st_q;
    logic                    aw_got_q, w_got_q;
    logic [11:0]             awaddr_q;
    logic [31:0]             wdata_q;
    logic [3:0]              wstrb_q;
    logic [1:0]              bresp_q;
    logic                    rvalid_q;
    logic [31:0]             rdata_q;
    logic [1:0]              rresp_q;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // two stages each, third stage holds previous value for edge detect
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            io_s1_q <= 1'b0;
            io_s2_q <= 1'b0;
            io_s3_q <= 1'b0;
            ck_s1_q <= 1'b0;
            ck_s2_q <= 1'b0;
            ck_s3_q <= 1'b0;
        end else begin
            io_s1_q <= i_timer_io_pin;
            io_s2_q <= io_s1_q;
            io_s3_q <= io_s2_q;
            ck_s1_q <= i_timer_clock_pin;
            ck_s2_q <= ck_s1_q;
            ck_s3_q <= ck_s2_q;
        end
    end

    // ------------------------------------------------------------
    // count clock select
    // ------------------------------------------------------------
    logic tick;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            div_q <= 6'h0_0;
        end else if (i_hs_clk_en) begin
            div_q <= div_q + 6'h0_1;
        end
    end

    // one enable per selected clock source
    always_comb begin
        case (ctrl0_q.count_clock_select)
            3'b000:  tick = (div_q[1:0] == 2'b11) && i_hs_clk_en;  // high-speed tick/4 via prescaler
            3'b001:  tick = 1'b1;
            3'b010:  tick = i_hs_clk_en && (div_q[3:0] == 4'hF);
            3'b011:  tick = i_hs_clk_en && (div_q == 6'h3_F);
            3'b100:  tick = i_tbc_clk_en;
            3'b101:  tick = i_hs_clk_en;
            3'b110:  tick = ck_s2_q & ~ck_s3_q;
            default: tick = ~ck_s2_q & ck_s3_q;
        endcase
    end

    // ------------------------------------------------------------
    // comparators and counter
    // ------------------------------------------------------------
    logic cap_mode, run_rise, per_match, ovf, cap_src, cap_edge;
    assign cap_mode  = (ctrl1_q.mode_select == ptc_pkg::PTC_MODE_CAP);
    assign run_rise  = ctrl0_q.counter_run_bit & ~run_prev_q;
    // period zero means no match; counter wraps after full range
    assign per_match = (per_q != '0) && (count_q == per_q) && tick;
    assign ovf       = (count_q == '1) && tick;
    assign cap_src   = ctrl1_q.capture_source_select ? ck_s2_q : io_s2_q;
    assign cap_edge  = cap_mode &&
                       edge_hit(ctrl1_q.pin_function, cap_src,
                                ctrl1_q.capture_source_select ? ck_s3_q : io_s3_q);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= ctrl0_q.counter_run_bit;
        end
    end

    // counter: run rise clears, pause and run low hold; match or overflow clears
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            count_q <= '0;
        end else if (run_rise) begin
            count_q <= '0;
        end else if (ctrl0_q.counter_run_bit && !ctrl0_q.counter_pause_bit && tick) begin
            if (per_match || ovf) begin
                count_q <= '0;
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    logic counting;
    assign counting = ctrl0_q.counter_run_bit && !ctrl0_q.counter_pause_bit && !run_rise;

    // interrupt pulses, one cycle each
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cap_irq_q <= 1'b0;
            per_irq_q <= 1'b0;
        end else begin
            cap_irq_q <= cap_edge;
            per_irq_q <= cap_mode && counting && per_match;
        end
    end
    assign o_capture_irq = cap_irq_q;
    assign o_period_irq  = per_irq_q;

    // no output function in capture mode; pin left undriven
    assign o_timer_io_out  = 1'b0;
    assign o_timer_io_oe_n = 1'b1;

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    logic wr_go;
    assign o_awready = (wr_st_q == ptc_pkg::PTC_WR_IDLE) && !aw_got_q;
    assign o_wready  = (wr_st_q == ptc_pkg::PTC_WR_IDLE) && !w_got_q;
    assign wr_go     = (wr_st_q == ptc_pkg::PTC_WR_IDLE) &&
                       (aw_got_q || i_awvalid) && (w_got_q || i_wvalid);
    logic [11:0] wa;
    logic [31:0] wd;
    logic [3:0]  ws;
    assign wa = aw_got_q ? awaddr_q : i_awaddr;
    assign wd = w_got_q ? wdata_q : i_wdata;
    assign ws = w_got_q ? wstrb_q : i_wstrb;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_st_q  <= ptc_pkg::PTC_WR_IDLE;
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            awaddr_q <= 12'h0_00;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            bresp_q  <= 2'b00;
        end else begin
            case (wr_st_q)
                ptc_pkg::PTC_WR_IDLE: begin
                    if (wr_go) begin
                        wr_st_q  <= ptc_pkg::PTC_WR_RESP;
                        aw_got_q <= 1'b0;
                        w_got_q  <= 1'b0;
                        bresp_q  <= (wa[11:2] > `PTC_OFF_EVENTS >> 2) ? 2'b10 : 2'b00;
                    end else begin
                        if (i_awvalid && !aw_got_q) begin
                            aw_got_q <= 1'b1;
                            awaddr_q <= i_awaddr;
                        end
                        if (i_wvalid && !w_got_q) begin
                            w_got_q <= 1'b1;
                            wdata_q <= i_wdata;
                            wstrb_q <= i_wstrb;
                        end
                    end
                end
                ptc_pkg::PTC_WR_RESP: begin
                    if (i_bready) begin
                        wr_st_q <= ptc_pkg::PTC_WR_IDLE;
                    end
                end
                default: wr_st_q <= ptc_pkg::PTC_WR_IDLE;
            endcase
        end
    end
    assign o_bvalid = (wr_st_q == ptc_pkg::PTC_WR_RESP);
    assign o_bresp  = bresp_q;

    // control and compare registers; capture overrides software write to compare-A
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl0_q <= '0;
            ctrl1_q <= '0;
            cmpa_q  <= '0;
            per_q   <= '0;
        end else begin
            if (wr_go && wa == `PTC_OFF_CTRL0) begin
                ctrl0_q <= ptc_pkg::ptc_ctrl0_t'(5'(lane_merge({ctrl0_q, 3'b000}, wd, ws) >> 3));
            end
            if (wr_go && wa == `PTC_OFF_CTRL1) begin
                ctrl1_q <= ptc_pkg::ptc_ctrl1_t'(lane_merge(ctrl1_q, wd, ws));
            end
            if (wr_go && wa == `PTC_OFF_PER_LO) begin
                per_q[7:0] <= lane_merge(per_q[7:0], wd, ws);
            end
            if (wr_go && wa == `PTC_OFF_PER_HI && ws[0]) begin
                per_q[CNT_W-1:8] <= wd[CNT_W-9:0];
            end
            if (wr_go && wa == `PTC_OFF_CMPA_LO) begin
                cmpa_q[7:0] <= lane_merge(cmpa_q[7:0], wd, ws);
            end
            if (wr_go && wa == `PTC_OFF_CMPA_HI && ws[0]) begin
                cmpa_q[CNT_W-1:8] <= wd[CNT_W-9:0];
            end
            if (cap_edge) begin
                cmpa_q <= count_q;
            end
        end
    end

    // sticky event flags, write one to clear; a new event wins over the clear
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cap_flag_q <= 1'b0;
            per_flag_q <= 1'b0;
        end else begin
            cap_flag_q <= cap_edge | (cap_flag_q & ~(wr_go && wa == `PTC_OFF_EVENTS && ws[0] && wd[0]));
            per_flag_q <= per_irq_q | (per_flag_q & ~(wr_go && wa == `PTC_OFF_EVENTS && ws[0] && wd[1]));
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel, one cycle answer
    // ------------------------------------------------------------
    assign o_arready = !rvalid_q;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= 2'b00;
        end else if (i_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q  <= 2'b00;
            case (i_araddr)
                `PTC_OFF_CTRL0:   rdata_q <= {24'h00_0000, {ctrl0_q, 3'b000}};
                `PTC_OFF_CTRL1:   rdata_q <= {24'h00_0000, ctrl1_q};
                `PTC_OFF_CNT_LO:  rdata_q <= {24'h00_0000, count_q[7:0]};
                `PTC_OFF_CNT_HI:  rdata_q <= {30'h0000_0000, count_q[CNT_W-1:8]};
                `PTC_OFF_CMPA_LO: rdata_q <= {24'h00_0000, cmpa_q[7:0]};
                `PTC_OFF_CMPA_HI: rdata_q <= {30'h0000_0000, cmpa_q[CNT_W-1:8]};
                `PTC_OFF_PER_LO:  rdata_q <= {24'h00_0000, per_q[7:0]};
                `PTC_OFF_PER_HI:  rdata_q <= {30'h0000_0000, per_q[CNT_W-1:8]};
                `PTC_OFF_EVENTS:  rdata_q <= {30'h0000_0000, per_flag_q, cap_flag_q};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= 2'b10;
                end
            endcase
        end else if (i_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign o_rvalid = rvalid_q;
    assign o_rdata  = rdata_q;
    assign o_rresp  = rresp_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_MODE_GATE: assert property (@(posedge i_clk) disable iff (i_rst)
        (!cap_mode && !wr_go) |=> $stable(cmpa_q) && !o_capture_irq)
        else $error("capture outside capture mode");

    AST_CAPTURE_LATCH: assert property (@(posedge i_clk) disable iff (i_rst)
        cap_edge |=> (cmpa_q == $past(count_q)) && o_capture_irq)
        else $error("capture did not latch counter");

    AST_RUN_CLEAR: assert property (@(posedge i_clk) disable iff (i_rst)
        run_rise |=> count_q == '0)
        else $error("run rise did not clear counter");

    AST_HOLD_STOPPED: assert property (@(posedge i_clk) disable iff (i_rst)
        (!ctrl0_q.counter_run_bit && !$past(ctrl0_q.counter_run_bit)) |-> $stable(count_q))
        else $error("stopped counter moved");

    AST_PAUSE_FREEZE: assert property (@(posedge i_clk) disable iff (i_rst)
        (ctrl0_q.counter_pause_bit && !run_rise) |=> $stable(count_q))
        else $error("paused counter moved");

    AST_PERIOD_CLEAR: assert property (@(posedge i_clk) disable iff (i_rst)
        (cap_mode && counting && per_match) |=> (count_q == '0) && o_period_irq)
        else $error("period match mishandled");

    AST_FULL_RANGE: assert property (@(posedge i_clk) disable iff (i_rst)
        (per_q == '0 && counting && tick && count_q != '1) |=> count_q == $past(count_q) + 1'b1)
        else $error("zero period cut the count short");

    AST_DISABLED_EDGE: assert property (@(posedge i_clk) disable iff (i_rst)
        (ctrl1_q.pin_function == ptc_pkg::PTC_EDGE_OFF && !wr_go) |=> $stable(cmpa_q) && !o_capture_irq)
        else $error("capture while disabled");

    AST_NO_OUTPUT: assert property (@(posedge i_clk) disable iff (i_rst)
        o_timer_io_oe_n)
        else $error("pin driven in capture mode");

endmodule
